//--- psm_params.svh
// psm_params.svh - field positions, reset values and cycle counts of the power save block
`ifndef PSM_PARAMS_SVH
`define PSM_PARAMS_SVH

// ****************************************************************
// reset control register fields
// ****************************************************************
`define PSM_CORE_REG_KEEP_BIT  8
`define PSM_FLASH_REG_KEEP_BIT 11
`define PSM_RCTL_WIDTH         16

// ****************************************************************
// reset values
// ****************************************************************
`define PSM_CLK_SEL_RST        3'h0
`define PSM_CNT_RST            2'h0

// ****************************************************************
// wake timing, in system clock cycles from wake decision to resume
// ****************************************************************
`define PSM_WAKE_MIN_CYC       2
`define PSM_WAKE_MAX_CYC       4
`define PSM_IDLE_WAKE_CNT      2'h1
`define PSM_SLEEP_WAKE_CNT     2'h2

`endif

//--- psm_pkg.sv
// psm_pkg.sv - types shared by the power save block
package psm_pkg;

  // ****************************************************************
  // requested mode, taken from the power save instruction operand
  // ****************************************************************
  typedef enum logic
  {
    PSM_MODE_SLEEP = 1'b0,
    PSM_MODE_IDLE  = 1'b1
  } psm_mode_e;

  // ****************************************************************
  // controller states, gray coded along run-enter-sleep-wake-run; idle to wake changes all three bits
  // ****************************************************************
  typedef enum logic [2:0]
  {
    PSM_ST_RUN   = 3'h0,
    PSM_ST_ENTER = 3'h1,
    PSM_ST_SLEEP = 3'h3,
    PSM_ST_IDLE  = 3'h5,
    PSM_ST_WAKE  = 3'h2
  } psm_state_e;

  typedef logic [2:0] psm_clk_sel_t;

  // ****************************************************************
  // register state of the controller
  // ****************************************************************
  typedef struct packed
  {
    psm_state_e   state;
    logic [1:0]   cnt;
    psm_clk_sel_t clk_sel;
    logic         deferred;
    logic         wdt_clr;
    logic         resume;
    psm_mode_e    mode;
  } psm_state_s;

  // ****************************************************************
  // power save request from the core
  // ****************************************************************
  typedef struct packed
  {
    logic      valid;
    psm_mode_e mode;
  } psm_req_s;

endpackage

//--- psm_sync.sv
// psm_sync.sv - two flip-flop synchroniser for a group of levels
`timescale 1ns/100ps

module psm_sync
  import psm_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // meta_q feeds sync_q only
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

//--- psm_periph_gate.sv
// psm_periph_gate.sv - clock enable of one peripheral in the power save modes
`timescale 1ns/100ps

module psm_periph_gate
  import psm_pkg::*;
(
  // mode decode
  input  wire logic in_sleep_in,
  input  wire logic in_idle_in,
  // peripheral properties
  input  wire logic needs_sysclk_in,
  input  wire logic stop_in_idle_bit_in,
  // enable
  output logic      run_en_out
);

  // peripherals clocked from an external input keep running in sleep
  assign run_en_out = !(in_sleep_in && needs_sysclk_in)
                   && !(in_idle_in && stop_in_idle_bit_in);

endmodule

//--- psm_ctrl.sv
// psm_ctrl.sv - sleep and idle power save controller
`timescale 1ns/100ps
`include "psm_params.svh"


module psm_ctrl
  import psm_pkg::*;
#(
  parameter int N_IRQ    = 8,
  parameter int N_PERIPH = 8
)
(
  // clock and reset
  input  wire logic                       mclk_in,
  input  wire logic                       rst_in,
  // power save request from the core
  input  wire psm_req_s                   psave_req_in,
  input  wire psm_clk_sel_t               clk_sel_in,
  input  wire logic                       clk_src_onchip_in,
  // configuration
  input  wire logic [`PSM_RCTL_WIDTH-1:0] reset_control_register_in,
  input  wire logic                       wdt_enabled_in,
  input  wire logic                       clk_monitor_en_in,
  // wake sources
  input  wire logic [N_IRQ-1:0]           irq_flag_in,
  input  wire logic [N_IRQ-1:0]           irq_enable_in,
  input  wire logic                       reset_event_in,
  input  wire logic                       wdt_timeout_in,
  // peripheral properties
  input  wire logic [N_PERIPH-1:0]        periph_needs_sysclk_in,
  input  wire logic [N_PERIPH-1:0]        stop_in_idle_bit_in,
  // clock and oscillator control
  output logic                            sys_clk_en_out,
  output logic                            osc_en_out,
  output logic                            core_clk_en_out,
  output logic                            low_power_rc_clock_run_out,
  output logic                            clock_failure_monitor_active_out,
  output psm_clk_sel_t                    clk_sel_out,
  // watchdog
  output logic                            wdt_clear_out,
  // regulators
  output logic                            core_reg_standby_out,
  output logic                            flash_reg_standby_out,
  // peripherals
  output logic [N_PERIPH-1:0]             periph_run_en_out,
  output logic                            input_change_notification_en_out,
  // core status
  output logic                            in_sleep_out,
  output logic                            in_idle_out,
  output logic                            resume_out
);

  // ****************************************************************
  // synchronised wake sources
  // ****************************************************************
  logic [N_IRQ-1:0] irq_flag_s;
  logic [1:0]       evt_s;
  logic             irq_wake;
  logic             wake_any;

  // interrupt flags may come from peripherals on an external clock
  psm_sync #(
    .WIDTH (N_IRQ)
  ) u_irq_sync (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .async_in (irq_flag_in),
    .sync_out (irq_flag_s)
  );

  // reset request and watchdog time-out come from other clock domains
  psm_sync #(
    .WIDTH (2)
  ) u_evt_sync (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .async_in ({reset_event_in, wdt_timeout_in}),
    .sync_out (evt_s)
  );

  assign irq_wake = |(irq_flag_s & irq_enable_in);
  assign wake_any = irq_wake || evt_s[1] || evt_s[0];

  // ****************************************************************
  // controller state
  // ****************************************************************
  psm_state_s st_q;
  psm_state_s st_d;

  always_comb
  begin
    st_d         = st_q;
    st_d.wdt_clr = 1'b0;
    st_d.resume  = 1'b0;
    unique case (st_q.state)
      PSM_ST_RUN:
      begin
        st_d.clk_sel  = clk_sel_in;
        st_d.deferred = 1'b0;
        if (psave_req_in.valid)
        begin
          st_d.state   = PSM_ST_ENTER;
          st_d.mode    = psave_req_in.mode;
          st_d.wdt_clr = 1'b1;
        end
      end
      PSM_ST_ENTER:
      begin
        // wake events are held off until the mode is reached
        st_d.deferred = wake_any;
        if (st_q.mode == PSM_MODE_SLEEP)
        begin
          st_d.state = PSM_ST_SLEEP;
        end
        else
        begin
          st_d.state = PSM_ST_IDLE;
        end
      end
      PSM_ST_SLEEP:
      begin
        if (wake_any || st_q.deferred)
        begin
          st_d.state    = PSM_ST_WAKE;
          st_d.cnt      = `PSM_SLEEP_WAKE_CNT;
          st_d.deferred = 1'b0;
        end
      end
      PSM_ST_IDLE:
      begin
        if (wake_any || st_q.deferred)
        begin
          st_d.state    = PSM_ST_WAKE;
          st_d.cnt      = `PSM_IDLE_WAKE_CNT;
          st_d.deferred = 1'b0;
        end
      end
      PSM_ST_WAKE:
      begin
        if (st_q.cnt == 2'h0)
        begin
          st_d.state  = PSM_ST_RUN;
          st_d.resume = 1'b1;
        end
        else
        begin
          st_d.cnt = st_q.cnt - 2'h1;
        end
      end
      default:
      begin
        st_d.state = PSM_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q.state    <= PSM_ST_RUN;
      st_q.cnt      <= `PSM_CNT_RST;
      st_q.clk_sel  <= `PSM_CLK_SEL_RST;
      st_q.deferred <= 1'b0;
      st_q.wdt_clr  <= 1'b0;
      st_q.resume   <= 1'b0;
      st_q.mode     <= PSM_MODE_SLEEP;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // mode decode and clock control
  // ****************************************************************
  logic in_sleep;
  logic in_idle;
  logic core_keep;
  logic flash_keep;

  assign in_sleep   = (st_q.state == PSM_ST_SLEEP);
  assign in_idle    = (st_q.state == PSM_ST_IDLE);
  assign core_keep  = reset_control_register_in[`PSM_CORE_REG_KEEP_BIT];
  assign flash_keep = reset_control_register_in[`PSM_FLASH_REG_KEEP_BIT];

  assign sys_clk_en_out = !in_sleep;
  // an off-chip source is only gated, its oscillator is not ours to stop
  assign osc_en_out = !(in_sleep && clk_src_onchip_in);
  // core clock returns in the wake state so the pipeline can refill
  assign core_clk_en_out = !in_sleep && !in_idle
                        && (st_q.state != PSM_ST_ENTER);
  assign clock_failure_monitor_active_out = clk_monitor_en_in && !in_sleep;
  assign low_power_rc_clock_run_out = wdt_enabled_in
                                   || (clk_monitor_en_in && !in_sleep);
  // frozen outside run so wake restarts on the entry source
  assign clk_sel_out = st_q.clk_sel;
  assign wdt_clear_out = st_q.wdt_clr && wdt_enabled_in;

  assign core_reg_standby_out  = in_sleep && !core_keep;
  assign flash_reg_standby_out = in_sleep && !flash_keep;

  assign input_change_notification_en_out = 1'b1;
  assign in_sleep_out = in_sleep;
  assign in_idle_out  = in_idle;
  assign resume_out   = st_q.resume;

  // ****************************************************************
  // peripheral gating
  // ****************************************************************
  for (genvar i = 0; i < N_PERIPH; i++)
  begin : g_periph
    psm_periph_gate u_gate (
      .in_sleep_in         (in_sleep),
      .in_idle_in          (in_idle),
      .needs_sysclk_in     (periph_needs_sysclk_in[i]),
      .stop_in_idle_bit_in (stop_in_idle_bit_in[i]),
      .run_en_out          (periph_run_en_out[i])
    );
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  sleep_osc_off_a: assert property (
    in_sleep && clk_src_onchip_in |-> !osc_en_out && !sys_clk_en_out)
    else $error("oscillator or system clock running in sleep");

  sleep_monitor_off_a: assert property (
    in_sleep |-> !clock_failure_monitor_active_out)
    else $error("clock monitor active in sleep");

  sleep_low_power_rc_clock_run_a: assert property (
    in_sleep && wdt_enabled_in |-> low_power_rc_clock_run_out)
    else $error("rc clock stopped in sleep with watchdog on");

  entry_wdt_clear_a: assert property (
    st_q.state == PSM_ST_RUN && psave_req_in.valid && wdt_enabled_in
    |=> wdt_clear_out ##1 (in_sleep || in_idle))
    else $error("watchdog not cleared ahead of the power save mode");

  sleep_ext_periph_a: assert property (
    in_sleep |-> input_change_notification_en_out
             && &(periph_run_en_out | periph_needs_sysclk_in))
    else $error("external clock peripheral stopped in sleep");

  sleep_periph_off_a: assert property (
    in_sleep |-> (periph_run_en_out & periph_needs_sysclk_in) == '0)
    else $error("system clock peripheral enabled in sleep");

  sleep_wake_a: assert property (
    in_sleep && wake_any |=> st_q.state == PSM_ST_WAKE)
    else $error("sleep did not end on wake event");

  clk_sel_hold_a: assert property (
    st_q.state != PSM_ST_RUN |=> $stable(clk_sel_out))
    else $error("clock source changed while saving power");

  core_reg_mode_a: assert property (
    in_sleep |-> core_reg_standby_out == !core_keep
             && flash_reg_standby_out == !flash_keep)
    else $error("regulator standby does not follow keep bits");

  reg_active_run_a: assert property (
    !in_sleep |-> !core_reg_standby_out && !flash_reg_standby_out)
    else $error("regulator in standby outside sleep");

  idle_core_stop_a: assert property (
    in_idle |-> !core_clk_en_out && sys_clk_en_out)
    else $error("core clocked or system clock stopped in idle");

  idle_entry_clear_a: assert property (
    $rose(in_idle) && wdt_enabled_in |-> $past(wdt_clear_out))
    else $error("idle entered without watchdog clear");

  idle_periph_run_a: assert property (
    in_idle |-> (periph_run_en_out | stop_in_idle_bit_in) == '1)
    else $error("peripheral stopped in idle without its bit");

  idle_low_power_rc_clock_run_a: assert property (
    in_idle && (wdt_enabled_in || clk_monitor_en_in) |-> low_power_rc_clock_run_out)
    else $error("rc clock stopped in idle");

  idle_wake_a: assert property (
    in_idle && wake_any |=> st_q.state == PSM_ST_WAKE)
    else $error("idle did not end on wake event");

  idle_resume_time_a: assert property (
    in_idle && wake_any |-> ##[2:4] resume_out)
    else $error("execution did not resume within four cycles");

  idle_stop_bit_a: assert property (
    in_idle |-> (periph_run_en_out & stop_in_idle_bit_in) == '0)
    else $error("stop-in-idle peripheral still running");

  entry_defer_a: assert property (
    st_q.state == PSM_ST_ENTER && wake_any
    |=> (in_sleep || in_idle) ##1 st_q.state == PSM_ST_WAKE)
    else $error("coincident interrupt not deferred then honoured");

  sleep_hold_a: assert property (
    in_sleep && !wake_any && !st_q.deferred |=> in_sleep)
    else $error("sleep left without a wake event");

  idle_hold_a: assert property (
    in_idle && !wake_any && !st_q.deferred |=> in_idle)
    else $error("idle left without a wake event");

  enter_core_stop_a: assert property (
    st_q.state == PSM_ST_ENTER |-> !core_clk_en_out)
    else $error("core clocked during entry");

  wake_clock_back_a: assert property (
    st_q.state == PSM_ST_WAKE |-> core_clk_en_out && sys_clk_en_out)
    else $error("core clock not reapplied on wake");

  resume_pulse_a: assert property (
    resume_out |=> !resume_out)
    else $error("resume held longer than one cycle");

endmodule

//--- psm_core_model.sv
// psm_core_model.sv - core, interrupt source and watchdog model facing the power save block
`timescale 1ns/100ps

module psm_core_model
  import psm_pkg::*;
(
  // clock
  input  wire logic mclk_in,
  // towards the block
  output psm_req_s   psave_req_out,
  output logic [7:0] irq_flag_out,
  output logic       reset_event_out,
  output logic       wdt_timeout_out
);
  initial
  begin
    psave_req_out   = '0;
    irq_flag_out    = 8'h00;
    reset_event_out = 1'b0;
    wdt_timeout_out = 1'b0;
  end

  // ****************************************************************
  // power save instruction: one-cycle pulse carrying the operand mode
  // ****************************************************************
  task automatic issue(input psm_mode_e m, input logic irq);
    @(posedge mclk_in);
    if (irq)
    begin
      // raised a cycle early so the synchronised flag lands while entry is under way
      irq_flag_out[0] <= 1'b1;
      @(posedge mclk_in);
    end
    psave_req_out <= '{valid: 1'b1, mode: m};
    @(posedge mclk_in);
    psave_req_out.valid <= 1'b0;
  endtask

  // ****************************************************************
  // wake sources: 0 interrupt flag, 1 reset event, 2 watchdog time-out
  // ****************************************************************
  // sources are held until released so the two-flop sync always sees them
  task automatic set_wake(input int k, input logic v);
    @(posedge mclk_in);
    case (k)
      0:       irq_flag_out[0] <= v;
      1:       reset_event_out <= v;
      default: wdt_timeout_out <= v;
    endcase
  endtask
endmodule

//--- testbench.sv
// testbench.sv - self-checking bench of the power save controller
`timescale 1ns/100ps

module testbench;
  import psm_pkg::*;

  logic         mclk_in = 1'b0;
  logic         rst_in = 1'b1;
  psm_req_s     req;
  psm_clk_sel_t clk_sel_in = 3'h0;
  logic         onchip = 1'b0;
  logic [15:0]  rst_ctl = 16'h0000;
  logic         wdt_en = 1'b0;
  logic         mon_en = 1'b0;
  logic [7:0]   irq_flag;
  logic [7:0]   irq_en = 8'h00;
  logic         rst_ev;
  logic         wdt_to;
  logic         sys_clk_en, osc_en, core_clk_en, rc_run, mon_act;
  psm_clk_sel_t clk_sel_out;
  logic         wdt_clear, core_stby, flash_stby, chg_en;
  logic         in_sleep, in_idle, resume;
  logic [7:0]   periph_en;
  int           fails = 0;
  int           total_checks = 0;

  always #20 mclk_in = ~mclk_in;

  psm_core_model psm_core_model_inst
  (
    .mclk_in         (mclk_in),
    .psave_req_out   (req),
    .irq_flag_out    (irq_flag),
    .reset_event_out (rst_ev),
    .wdt_timeout_out (wdt_to)
  );

  psm_ctrl psm_ctrl_inst
  (
    .mclk_in                          (mclk_in),
    .rst_in                           (rst_in),
    .psave_req_in                     (req),
    .clk_sel_in                       (clk_sel_in),
    .clk_src_onchip_in                (onchip),
    .reset_control_register_in        (rst_ctl),
    .wdt_enabled_in                   (wdt_en),
    .clk_monitor_en_in                (mon_en),
    .irq_flag_in                      (irq_flag),
    .irq_enable_in                    (irq_en),
    .reset_event_in                   (rst_ev),
    .wdt_timeout_in                   (wdt_to),
    .periph_needs_sysclk_in           (8'h0F),
    .stop_in_idle_bit_in              (8'h33),
    .sys_clk_en_out                   (sys_clk_en),
    .osc_en_out                       (osc_en),
    .core_clk_en_out                  (core_clk_en),
    .low_power_rc_clock_run_out       (rc_run),
    .clock_failure_monitor_active_out (mon_act),
    .clk_sel_out                      (clk_sel_out),
    .wdt_clear_out                    (wdt_clear),
    .core_reg_standby_out             (core_stby),
    .flash_reg_standby_out            (flash_stby),
    .periph_run_en_out                (periph_en),
    .input_change_notification_en_out (chg_en),
    .in_sleep_out                     (in_sleep),
    .in_idle_out                      (in_idle),
    .resume_out                       (resume)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic sel(input int k);
    case (k)
      0:       return in_sleep;
      1:       return in_idle;
      2:       return core_clk_en;
      default: return resume;
    endcase
  endfunction

  // bounded wait on a settled output, sampled on the falling edge
  task automatic wait_for(input int k, output int n);
    n = 0;
    while (sel(k) !== 1'b1)
    begin
      @(negedge mclk_in);
      n++;
      if (n > 12)
      begin
        fails++;
        $display("Error at %0t: wait %0d timed out", $time, k);
        summarize();
      end
    end
  endtask

  task automatic cfg(input logic w, input logic f, input logic o, input logic [15:0] r);
    @(posedge mclk_in);
    wdt_en  <= w;
    mon_en  <= f;
    onchip  <= o;
    rst_ctl <= r;
  endtask

  task automatic enter(input psm_mode_e m);
    int n;
    psm_core_model_inst.issue(m, 1'b0);
    @(negedge mclk_in);
    check(wdt_clear, wdt_en, "watchdog clear");
    check(core_clk_en, 1'b0, "core clock");
    wait_for((m == PSM_MODE_IDLE) ? 1 : 0, n);
  endtask

  // core clock comes back first, execution resumes 2 to 4 cycles later
  task automatic resume_time();
    int n;
    wait_for(2, n);
    wait_for(3, n);
    check(n >= 2 && n <= 4, 1'b1, "resume delay");
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_idle();
    int n;
    cfg(1'b0, 1'b1, 1'b1, 16'h0000);
    enter(PSM_MODE_IDLE);
    check({sys_clk_en, osc_en, in_sleep}, 3'h6, "idle clocks");
    check(rc_run, 1'b1, "rc clock by monitor");
    check(periph_en, 8'hCC, "stop in idle");
    // a disabled interrupt must not wake the core
    psm_core_model_inst.set_wake(0, 1'b1);
    repeat (6) @(negedge mclk_in);
    check(in_idle, 1'b1, "disabled irq");
    @(posedge mclk_in);
    irq_en <= 8'h01;
    resume_time();
    psm_core_model_inst.set_wake(0, 1'b0);
    repeat (3) @(posedge mclk_in);
  endtask

  task automatic t_sleep();
    logic [15:0] r;
    for (int k = 0; k < 4; k++)
    begin
      r = 16'h0000;
      r[8] = k[0];
      r[11] = k[1];
      // pass 2 runs from an off-chip source, whose oscillator is left alone
      cfg(k != 3, 1'b1, k != 2, r);
      clk_sel_in <= 3'h5;
      repeat (2) @(posedge mclk_in);
      enter(PSM_MODE_SLEEP);
      check({sys_clk_en, osc_en}, {1'b0, k == 2}, "sleep clocks");
      check(mon_act, 1'b0, "monitor in sleep");
      check(rc_run, k != 3, "rc clock in sleep");
      check(chg_en, 1'b1, "change notification");
      check(periph_en, 8'hF0, "sysclk peripherals");
      check(core_stby, !k[0], "core regulator");
      check(flash_stby, !k[1], "flash regulator");
      psm_core_model_inst.set_wake(k % 3, 1'b1);
      clk_sel_in <= 3'h2;
      resume_time();
      check(clk_sel_out, 3'h5, "clock source kept");
      psm_core_model_inst.set_wake(k % 3, 1'b0);
      repeat (3) @(posedge mclk_in);
    end
  endtask

  // interrupt coincident with the request: entry completes, then wake
  task automatic t_deferred();
    int n;
    cfg(1'b1, 1'b0, 1'b1, 16'h0000);
    psm_core_model_inst.issue(PSM_MODE_IDLE, 1'b1);
    @(negedge mclk_in);
    check(wdt_clear, 1'b1, "idle watchdog clear");
    wait_for(1, n);
    check(in_idle, 1'b1, "entry completed");
    check(rc_run, 1'b1, "rc clock by watchdog");
    resume_time();
    psm_core_model_inst.set_wake(0, 1'b0);
    repeat (3) @(posedge mclk_in);
  endtask

  task automatic t_reset_wake();
    enter(PSM_MODE_SLEEP);
    @(posedge mclk_in);
    rst_in <= 1'b1;
    @(posedge mclk_in);
    rst_in <= 1'b0;
    @(negedge mclk_in);
    check({in_sleep, sys_clk_en, core_clk_en}, 3'h3, "reset wake");
  endtask

  initial
  begin
    @(negedge mclk_in);
    check({sys_clk_en, osc_en, core_clk_en, wdt_clear, resume}, 5'h1C, "reset outputs");
    check({core_stby, flash_stby, periph_en, clk_sel_out}, 13'h07F8, "reset values");
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_idle();
    t_sleep();
    t_deferred();
    t_reset_wake();
    summarize();
  end
endmodule
